// ### rtl/ldio_ctrl.sv
// Discrete contact control port of a diode laser with an AXI4-Lite register slave.
// Assumes contacts arrive asynchronously; energy, temperature and fault inputs
// come from logic on sys_clk_i.
// Behaviour
// - Act on contacts other than legacy stop only while select closed
// - Fire closing with halt closed starts emission
// - Halt during repeated emission ends it
// - Supply switch contact turns diode supply on/off
// - Guide beam follows guide contact
// - Alarm clears on fault clear after cause gone
// - Legacy stop open forces emergency stop
// - Supply-prepared contact follows diode supply
// - Ready when able to emit and schedule valid
// - Fault contact open until fault reset
// - Emission indicator closed while emitting
// - Energy inside limits closes monitor-good for time
// - Energy outside limits closes monitor-bad, error 035
// - Temperature outside window closes alert contact
// - End contact closes for 20 ms after emission
// - Input-accepted contact mirrors control select
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module ldio_ctrl #(
    parameter int unsigned MS_CYC_P  = ldio_pkg::MS_CYC,
    parameter int unsigned END_CYC_P = ldio_pkg::END_CYC
) (
    // Clock and reset
    input  wire logic              sys_clk_i,
    input  wire logic              rst_n_i,
    // Contacts
    input  wire ldio_pkg::ldio_cin_s contacts_i,
    output ldio_pkg::ldio_cout_s   contacts_o,
    // Internal laser status and drives
    input  wire logic              key_on_i,
    input  wire logic              fault_cause_i,
    input  wire logic              energy_vld_i,
    input  wire logic [15:0]       energy_i,
    input  wire logic [15:0]       temp_i,
    output logic                   laser_on_o,
    output logic                   guide_on_o,
    output logic                   supply_on_o,
    output logic                   estop_o,
    // AXI4-Lite slave
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);
    import ldio_pkg::*;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic in_win(input logic [15:0] v, input logic [31:0] lim);
        return (v >= lim[15:0]) && (v <= lim[HI_LSB +: 16]);
    endfunction : in_win

    // Contact synchroniser and debounce filter.
    logic [6:0]       s1_r, s2_r, s3_r, flt_r, flt_nxt;
    logic [DEB_W-1:0] deb_r [7];
    logic [DEB_W-1:0] deb_nxt [7];
    ldio_cin_s        flt;
    assign flt = ldio_cin_s'(flt_r);

    always_comb begin
        flt_nxt = flt_r;
        for (int i = 0; i < 7; i++) begin
            deb_nxt[i] = '0;
            if (s2_r[i] == s3_r[i] && s3_r[i] != flt_r[i]) begin
                if (deb_r[i] == DEB_W'(DEB_CYC - 1)) begin
                    flt_nxt[i] = s3_r[i];
                end else begin
                    deb_nxt[i] = deb_r[i] + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            s1_r  <= '0;
            s2_r  <= '0;
            s3_r  <= '0;
            flt_r <= '0;
            for (int i = 0; i < 7; i++) begin
                deb_r[i] <= '0;
            end
        end else begin
            s1_r  <= contacts_i;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            flt_r <= flt_nxt;
            deb_r <= deb_nxt;
        end
    end

    // Register file and AXI4-Lite slave.
    logic [31:0] cfg_r [CFG_N];
    logic [31:0] cfg_nxt [CFG_N];
    logic        aw_r, aw_nxt, w_r, w_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
    logic [7:0]  awa_r, awa_nxt;
    logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt, stat_c;
    logic [3:0]  ws_r, ws_nxt;
    logic [1:0]  br_r, br_nxt, rr_r, rr_nxt;
    logic [7:0]  err_r, err_nxt;
    ldio_cout_s  cout_r, cout_nxt;
    logic        alarm_r, alarm_nxt, estop_c;

    assign stat_c = {13'h0000, estop_c, alarm_r, cout_r, 1'b0, flt_r};
    assign s_axi_awready = !aw_r && !bv_r;
    assign s_axi_wready  = !w_r && !bv_r;
    assign s_axi_arready = !rv_r;

    always_comb begin
        aw_nxt  = aw_r;
        w_nxt   = w_r;
        awa_nxt = awa_r;
        wd_nxt  = wd_r;
        ws_nxt  = ws_r;
        bv_nxt  = bv_r;
        br_nxt  = br_r;
        rv_nxt  = rv_r;
        rd_nxt  = rd_r;
        rr_nxt  = rr_r;
        cfg_nxt = cfg_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_nxt  = 1'b1;
            awa_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_nxt  = 1'b1;
            wd_nxt = s_axi_wdata;
            ws_nxt = s_axi_wstrb;
        end
        if (aw_r && w_r) begin
            aw_nxt = 1'b0;
            w_nxt  = 1'b0;
            bv_nxt = 1'b1;
            br_nxt = RESP_SLVERR;
            if (awa_r[7:2] < 6'(CFG_N)) begin
                cfg_nxt[awa_r[4:2]] = merge(cfg_r[awa_r[4:2]], wd_r, ws_r);
                br_nxt = RESP_OKAY;
            end
        end
        if (bv_r && s_axi_bready) begin
            bv_nxt = 1'b0;
        end
        if (rv_r && s_axi_rready) begin
            rv_nxt = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rv_nxt = 1'b1;
            rr_nxt = RESP_OKAY;
            rd_nxt = 32'h0000_0000;
            if (s_axi_araddr[7:2] < 6'(CFG_N)) begin
                rd_nxt = cfg_r[s_axi_araddr[4:2]];
            end else if (s_axi_araddr[7:2] == A_STATUS[7:2]) begin
                rd_nxt = stat_c;
            end else if (s_axi_araddr[7:2] == A_ERROR[7:2]) begin
                rd_nxt = {24'h00_0000, err_r};
            end else begin
                rr_nxt = RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            aw_r  <= 1'b0;
            w_r   <= 1'b0;
            awa_r <= 8'h00;
            wd_r  <= 32'h0000_0000;
            ws_r  <= 4'h0;
            bv_r  <= 1'b0;
            br_r  <= RESP_OKAY;
            rv_r  <= 1'b0;
            rd_r  <= 32'h0000_0000;
            rr_r  <= RESP_OKAY;
            cfg_r <= CFG_RST;
        end else begin
            aw_r  <= aw_nxt;
            w_r   <= w_nxt;
            awa_r <= awa_nxt;
            wd_r  <= wd_nxt;
            ws_r  <= ws_nxt;
            bv_r  <= bv_nxt;
            br_r  <= br_nxt;
            rv_r  <= rv_nxt;
            rd_r  <= rd_nxt;
            rr_r  <= rr_nxt;
            cfg_r <= cfg_nxt;
        end
    end

    assign s_axi_bvalid = bv_r;
    assign s_axi_bresp  = br_r;
    assign s_axi_rvalid = rv_r;
    assign s_axi_rdata  = rd_r;
    assign s_axi_rresp  = rr_r;

    // Emission engine, supply, alarm and output contacts.
    ldio_eng_e   st_r, st_nxt;
    logic [31:0] cnt_r, cnt_nxt, end_r, end_nxt, good_r, good_nxt, bad_r, bad_nxt;
    logic [7:0]  rep_r, rep_nxt;
    logic        supply_r, supply_nxt, fire_d_r, halt_d_r, laser_r, guide_r;
    logic        act_c, able_c, ready_c, guide_c, stop_c, mon_ok_c;
    logic [31:0] on_cyc, gap_cyc, mon_cyc;

    assign act_c    = flt.sel;
    assign estop_c  = !flt.estop_n || !key_on_i;
    assign able_c   = supply_r && !alarm_r && !estop_c;
    assign ready_c  = able_c && cfg_r[0][CTRL_VALID_BIT];
    assign guide_c  = act_c && flt.guide && !estop_c;
    // Releasing halt, or closing it afresh, ends emission at once.
    assign stop_c   = !able_c || (act_c && (!flt.halt || (flt.halt && !halt_d_r)));
    assign mon_ok_c = in_win(energy_i, cfg_r[2]);
    assign on_cyc   = 32'(cfg_r[1][15:0]) * MS_CYC_P;
    assign gap_cyc  = 32'(cfg_r[1][HI_LSB +: 16]) * MS_CYC_P;
    assign mon_cyc  = 32'(cfg_r[4][15:0]) * MS_CYC_P;

    always_comb begin
        st_nxt     = st_r;
        cnt_nxt    = cnt_r;
        rep_nxt    = rep_r;
        end_nxt    = (end_r != 32'h0000_0000) ? end_r - 32'h0000_0001 : end_r;
        good_nxt   = (good_r != 32'h0000_0000) ? good_r - 32'h0000_0001 : good_r;
        bad_nxt    = (bad_r != 32'h0000_0000) ? bad_r - 32'h0000_0001 : bad_r;
        supply_nxt = estop_c ? 1'b0 : (act_c ? flt.supply : supply_r);
        alarm_nxt  = alarm_r;
        err_nxt    = err_r;
        case (st_r)
            ENG_IDLE: begin
                if (act_c && flt.fire && !fire_d_r && flt.halt && ready_c) begin
                    st_nxt  = ENG_EMIT;
                    cnt_nxt = on_cyc;
                    rep_nxt = cfg_r[0][CTRL_REP_LSB +: 8];
                end
            end
            ENG_EMIT, ENG_GAP: begin
                if (stop_c || (cnt_r <= 32'h0000_0001 && st_r == ENG_EMIT
                               && rep_r == 8'h00)) begin
                    st_nxt  = ENG_IDLE;
                    end_nxt = END_CYC_P;
                end else if (cnt_r <= 32'h0000_0001) begin
                    st_nxt  = (st_r == ENG_EMIT) ? ENG_GAP : ENG_EMIT;
                    cnt_nxt = (st_r == ENG_EMIT) ? gap_cyc : on_cyc;
                    rep_nxt = (st_r == ENG_EMIT) ? rep_r - 8'h01 : rep_r;
                end else begin
                    cnt_nxt = cnt_r - 32'h0000_0001;
                end
            end
            default: begin
                st_nxt = ENG_IDLE;
            end
        endcase
        if (act_c && flt.clear && !fault_cause_i) begin
            alarm_nxt = 1'b0;
            err_nxt   = 8'h00;
        end
        if (energy_vld_i && mon_ok_c) begin
            good_nxt = mon_cyc;
            bad_nxt  = 32'h0000_0000;
        end
        // A new fault wins over a clear in the same cycle.
        if (fault_cause_i) begin
            alarm_nxt = 1'b1;
        end
        if (energy_vld_i && !mon_ok_c) begin
            bad_nxt   = mon_cyc;
            good_nxt  = 32'h0000_0000;
            err_nxt   = ERR_MON_RANGE;
            alarm_nxt = 1'b1;
        end
        cout_nxt.in_accept  = act_c;
        cout_nxt.end_pulse  = end_r != 32'h0000_0000;
        cout_nxt.temp_alert = !in_win(temp_i, cfg_r[3]);
        cout_nxt.mon_bad    = bad_r != 32'h0000_0000;
        cout_nxt.mon_good   = good_r != 32'h0000_0000;
        cout_nxt.emitting   = st_r == ENG_EMIT;
        cout_nxt.no_fault   = !alarm_r;
        cout_nxt.ready      = ready_c;
        cout_nxt.supply_rdy = supply_r;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            st_r     <= ENG_IDLE;
            cnt_r    <= 32'h0000_0000;
            rep_r    <= 8'h00;
            end_r    <= 32'h0000_0000;
            good_r   <= 32'h0000_0000;
            bad_r    <= 32'h0000_0000;
            supply_r <= 1'b0;
            alarm_r  <= 1'b0;
            err_r    <= 8'h00;
            fire_d_r <= 1'b0;
            halt_d_r <= 1'b0;
            laser_r  <= 1'b0;
            guide_r  <= 1'b0;
            cout_r   <= '0;
        end else begin
            st_r     <= st_nxt;
            cnt_r    <= cnt_nxt;
            rep_r    <= rep_nxt;
            end_r    <= end_nxt;
            good_r   <= good_nxt;
            bad_r    <= bad_nxt;
            supply_r <= supply_nxt;
            alarm_r  <= alarm_nxt;
            err_r    <= err_nxt;
            fire_d_r <= flt.fire;
            halt_d_r <= flt.halt;
            laser_r  <= st_r == ENG_EMIT;
            guide_r  <= guide_c;
            cout_r   <= cout_nxt;
        end
    end

    assign contacts_o  = cout_r;
    assign laser_on_o  = laser_r;
    assign guide_on_o  = guide_r;
    assign supply_on_o = supply_r;
    assign estop_o     = estop_c;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_fire_ok;
        st_r == ENG_IDLE && act_c && flt.fire && !fire_d_r && flt.halt && ready_c;
    endsequence
    sequence s_emit_end;
        st_r != ENG_IDLE ##1 st_r == ENG_IDLE;
    endsequence

    a_ignore_inactive: assert property ((st_r == ENG_IDLE && !act_c) |=> st_r == ENG_IDLE)
        else $error("emission started while select open");
    a_fire_start: assert property (s_fire_ok |=> st_r == ENG_EMIT ##1 cout_r.emitting)
        else $error("fire did not start emission");
    a_halt_stop: assert property ((st_r != ENG_IDLE && act_c && !flt.halt) |=> st_r == ENG_IDLE)
        else $error("halt did not end emission");
    a_supply_on: assert property ((act_c && !estop_c && flt.supply) |=> supply_on_o ##1 cout_r.supply_rdy)
        else $error("supply did not follow switch");
    a_alarm_hold: assert property ((alarm_r && !(act_c && flt.clear)) |=> alarm_r)
        else $error("alarm cleared without fault clear");
    a_fault_open: assert property ($rose(alarm_r) |=> !cout_r.no_fault)
        else $error("fault contact not opened");
    a_end_pulse: assert property (s_emit_end |=> cout_r.end_pulse [*8])
        else $error("end contact not held");
    a_mon_bad: assert property ((energy_vld_i && !mon_ok_c && mon_cyc != 0) |=> err_r == ERR_MON_RANGE ##1 cout_r.mon_bad)
        else $error("monitor bad not raised");
    a_accept: assert property (1'b1 |=> cout_r.in_accept == $past(act_c))
        else $error("accept contact wrong");
    a_estop: assert property (estop_c |=> !supply_on_o ##1 !laser_on_o)
        else $error("emergency stop ignored");
    a_guide: assert property (1'b1 |=> guide_on_o == $past(guide_c))
        else $error("guide beam wrong");
    a_filter_agree: assert property ($changed(flt_r) |-> $past(s2_r) == $past(s3_r))
        else $error("filter changed on unstable input");
endmodule : ldio_ctrl

// ### rtl/ldio_pkg.sv
// Shared constants and carrier types for the laser discrete control port.
// Assumes a 10 MHz system clock; every contact bit reads 1 when closed.
package ldio_pkg;
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned MS_NS         = 1_000_000;
    localparam int unsigned MS_CYC        = MS_NS / CLK_PERIOD_NS;
    localparam int unsigned END_PULSE_MS  = 20;
    localparam int unsigned END_CYC       = END_PULSE_MS * MS_CYC;
    localparam int unsigned DEB_NS        = 200_000;
    localparam int unsigned DEB_CYC       = DEB_NS / CLK_PERIOD_NS;
    localparam int unsigned DEB_W         = $clog2(DEB_CYC + 1);

    // Register byte offsets.
    localparam logic [7:0] A_CTRL     = 8'h00;
    localparam logic [7:0] A_TIMING   = 8'h04;
    localparam logic [7:0] A_MON_LIM  = 8'h08;
    localparam logic [7:0] A_TEMP_WIN = 8'h0C;
    localparam logic [7:0] A_MON_TIME = 8'h10;
    localparam logic [7:0] A_STATUS   = 8'h14;
    localparam logic [7:0] A_ERROR    = 8'h18;
    localparam int unsigned CFG_N     = 5;

    // Field positions.
    localparam int unsigned CTRL_VALID_BIT = 0;
    localparam int unsigned CTRL_REP_LSB   = 8;
    localparam int unsigned HI_LSB         = 16;

    // Reset values, indexed by offset / 4.
    localparam logic [31:0] CFG_RST [CFG_N] = '{
        32'h0000_0000, 32'h0001_0001, 32'hFFFF_0000, 32'hFFFF_0000, 32'h0000_000A};

    localparam logic [7:0] ERR_MON_RANGE = 8'h23;
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;

    typedef struct packed {
        logic sel;
        logic fire;
        logic halt;
        logic supply;
        logic guide;
        logic clear;
        logic estop_n;
    } ldio_cin_s;

    typedef struct packed {
        logic in_accept;
        logic end_pulse;
        logic temp_alert;
        logic mon_bad;
        logic mon_good;
        logic emitting;
        logic no_fault;
        logic ready;
        logic supply_rdy;
    } ldio_cout_s;

    typedef enum logic [1:0] {ENG_IDLE, ENG_EMIT, ENG_GAP} ldio_eng_e;
endpackage : ldio_pkg

// ### verification/ldio_plc_model.sv
// PLC model driving the discrete contact inputs of the laser control port.
// Assumes the bench calls its tasks; every contact is a relay that bounces.
`timescale 1ns/1ps
module ldio_plc_model #(
    parameter int unsigned MIN_ON  = 2500,
    parameter int unsigned MIN_OFF = 2500
) (
    // Clock
    input  wire logic           clk_i,
    // Contacts
    output ldio_pkg::ldio_cin_s contacts_o
);
    import ldio_pkg::*;
    initial contacts_o = '0;
    // One bounce, then a wait until the port's filter has surely taken the level.
    task automatic drive(input int b, input logic v);
        for (int k = 0; k < 3; k++) begin
            @(posedge clk_i);
            contacts_o[b] <= v ^ (k == 1);
        end
        repeat (DEB_CYC + 20) @(posedge clk_i);
    endtask : drive
    // Hold times come from its own counts, never from the emission indicator.
    task automatic fire_once();
        if (contacts_o.halt !== 1'b1) drive(4, 1'b1);
        drive(5, 1'b1);
        repeat (MIN_ON) @(posedge clk_i);
        drive(5, 1'b0);
        repeat (MIN_OFF) @(posedge clk_i);
    endtask : fire_once
endmodule : ldio_plc_model

// ### verification/ldio_ctrl_tb.sv
// Self-checking bench for the laser discrete control port.
// Assumes the PLC model on the contacts and this bench as AXI4-Lite master.
`timescale 1ns/1ps
module ldio_ctrl_tb;
    import ldio_pkg::*;
    localparam int MS = 10;
    localparam int ENDC = 40;
    localparam int LAS = 12, GDE = 11, SUP = 10, EST = 9, ACC = 8, ENP = 7, TMP = 6;
    localparam int BAD = 5, GOOD = 4, NFLT = 2, RDY = 1, SRDY = 0;
    localparam int C_SEL = 6, C_HALT = 4, C_SUP = 3, C_GDE = 2, C_CLR = 1, C_EST = 0;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        key_on = 1'b1;
    logic        fcause = 1'b0;
    logic        evld = 1'b0;
    logic [15:0] energy = '0;
    logic [15:0] temp = 16'h0040;
    logic [7:0]  awa = '0;
    logic [7:0]  ara = '0;
    logic [31:0] wd = '0;
    logic [3:0]  ws = '0;
    logic        awv = 1'b0, wv = 1'b0, bo = 1'b0, arv = 1'b0, ro = 1'b0;
    logic        awr, wr, bv, arr, rv, las, gde, sup, est;
    logic [1:0]  bresp, rresp;
    logic [31:0] rd;
    ldio_cin_s   cin;
    ldio_cout_s  cout;
    wire  [12:0] obs = {las, gde, sup, est, cout};
    int          mismatches = 0;
    int          num_checks = 0;

    ldio_plc_model plc (.clk_i(clk), .contacts_o(cin));
    ldio_ctrl #(.MS_CYC_P(MS), .END_CYC_P(ENDC)) DUT (
        .sys_clk_i(clk), .rst_n_i(rst_n), .contacts_i(cin), .contacts_o(cout),
        .key_on_i(key_on), .fault_cause_i(fcause), .energy_vld_i(evld),
        .energy_i(energy), .temp_i(temp), .laser_on_o(las), .guide_on_o(gde),
        .supply_on_o(sup), .estop_o(est), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bo),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(ro));

    initial begin
        forever #50 clk = ~clk;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic ob(input string n, input int i, input logic v);
        @(negedge clk);
        chk(n, obs[i], v);
    endtask : ob

    task automatic wait_out(input string n, input int i, input logic v, input int lim);
        int k;
        for (k = 0; k < lim; k++) begin
            @(negedge clk);
            if (obs[i] === v) break;
        end
        chk(n, obs[i], v);
        if (k == lim) print_verdict();
    endtask : wait_out

    task automatic count_high(input int i, output int n);
        n = 0;
        while (obs[i] === 1'b1 && n < 30000) begin
            n++;
            @(negedge clk);
        end
    endtask : count_high

    task automatic hold(input string nm, input int i, input logic v, input int lim);
        int n = 0;
        repeat (lim) begin
            @(negedge clk);
            if (obs[i] !== v) n++;
        end
        chk(nm, n, 0);
    endtask : hold

    // Handshakes are judged at the falling edge, so the answer is read race-free.
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                       input logic [1:0] er);
        bit ha, hw, hb;
        int k;
        @(posedge clk);
        awa <= a;
        wd <= d;
        ws <= s;
        awv <= 1'b1;
        wv <= 1'b1;
        bo <= 1'b1;
        for (k = 0; k < 100; k++) begin
            @(negedge clk);
            ha = awv && awr;
            hw = wv && wr;
            hb = bv && bo;
            if (hb) chk("bresp", bresp, er);
            @(posedge clk);
            if (ha) awv <= 1'b0;
            if (hw) wv <= 1'b0;
            if (hb) begin
                bo <= 1'b0;
                break;
            end
        end
        if (k == 100) begin
            chk("write wait", k, 0);
            print_verdict();
        end
    endtask : axw

    task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        bit ha, hr;
        int k;
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        ro <= 1'b1;
        for (k = 0; k < 100; k++) begin
            @(negedge clk);
            ha = arv && arr;
            hr = rv && ro;
            if (hr) chk("rdata", rd, ed);
            if (hr) chk("rresp", rresp, er);
            @(posedge clk);
            if (ha) arv <= 1'b0;
            if (hr) begin
                ro <= 1'b0;
                break;
            end
        end
        if (k == 100) begin
            chk("read wait", k, 0);
            print_verdict();
        end
    endtask : axr

    task automatic sc_regs();
        for (int i = 0; i < CFG_N; i++) axr(8'(4 * i), CFG_RST[i], RESP_OKAY);
        axr(8'h1C, 32'h0, RESP_SLVERR);
        axw(A_STATUS, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
        axw(A_MON_TIME, 32'h0000_1234, 4'h2, RESP_OKAY);
        axr(A_MON_TIME, 32'h0000_120A, RESP_OKAY);
        axw(A_MON_TIME, 32'h0000_000A, 4'hF, RESP_OKAY);
        ob("estop", EST, 1'b1);
        ob("accept", ACC, 1'b0);
    endtask : sc_regs

    task automatic sc_access();
        plc.drive(C_EST, 1'b1);
        ob("estop", EST, 1'b0);
        plc.drive(C_SUP, 1'b1);
        ob("supply", SUP, 1'b0);
        plc.drive(C_SEL, 1'b1);
        ob("accept", ACC, 1'b1);
        ob("supply", SUP, 1'b1);
        ob("prepared", SRDY, 1'b1);
        ob("ready", RDY, 1'b0);
        axw(A_CTRL, 32'h1, 4'hF, RESP_OKAY);
        wait_out("ready", RDY, 1'b1, 10);
        plc.drive(C_GDE, 1'b1);
        ob("guide", GDE, 1'b1);
        plc.drive(C_SEL, 1'b0);
        ob("guide", GDE, 1'b0);
        ob("accept", ACC, 1'b0);
        plc.drive(C_SEL, 1'b1);
        ob("guide", GDE, 1'b1);
        plc.drive(C_GDE, 1'b0);
        ob("guide", GDE, 1'b0);
    endtask : sc_access

    task automatic sc_fire();
        int n;
        fork
            plc.fire_once();
            begin
                wait_out("laser", LAS, 1'b1, 5000);
                chk("emitting", cout.emitting, 1'b1);
                count_high(LAS, n);
                chk("emit len", n, MS);
                chk("emitting", cout.emitting, 1'b0);
                // The end contact closes at the same edge that drops the beam.
                chk("end", obs[ENP], 1'b1);
                count_high(ENP, n);
                chk("end len", n, ENDC);
            end
        join
    endtask : sc_fire

    task automatic sc_repeat();
        axw(A_TIMING, 32'h0064_0064, 4'hF, RESP_OKAY);
        axw(A_CTRL, 32'h0000_0301, 4'hF, RESP_OKAY);
        fork
            plc.fire_once();
            begin
                wait_out("laser", LAS, 1'b1, 5000);
                // Halt stays open from here on, far longer than 1 ms.
                plc.drive(C_HALT, 1'b0);
                hold("halted", LAS, 1'b0, 3000);
            end
        join
    endtask : sc_repeat

    task automatic sc_energy();
        logic [15:0] ev [3] = '{16'h0100, 16'h0200, 16'h0201};
        int n;
        axw(A_MON_LIM, 32'h0200_0100, 4'hF, RESP_OKAY);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            energy <= ev[i];
            evld <= 1'b1;
            @(posedge clk);
            evld <= 1'b0;
            wait_out("mon", i < 2 ? GOOD : BAD, 1'b1, 5);
            chk("mon other", obs[i < 2 ? BAD : GOOD], 1'b0);
            count_high(i < 2 ? GOOD : BAD, n);
            chk("mon len", n, 10 * MS);
        end
        axr(A_ERROR, 32'h23, RESP_OKAY);
        ob("fault", NFLT, 1'b0);
        ob("ready", RDY, 1'b0);
        @(posedge clk);
        fcause <= 1'b1;
        plc.drive(C_CLR, 1'b1);
        ob("fault", NFLT, 1'b0);
        plc.drive(C_CLR, 1'b0);
        fcause <= 1'b0;
        hold("fault", NFLT, 1'b0, 50);
        plc.drive(C_CLR, 1'b1);
        ob("fault", NFLT, 1'b1);
        plc.drive(C_CLR, 1'b0);
    endtask : sc_energy

    task automatic sc_temp();
        logic [15:0] tv [4] = '{16'h0050, 16'h0081, 16'h0020, 16'h001F};
        axw(A_TEMP_WIN, 32'h0080_0020, 4'hF, RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            temp <= tv[i];
            wait_out("temp", TMP, i % 2, 10);
        end
    endtask : sc_temp

    task automatic sc_stop();
        @(posedge clk);
        key_on <= 1'b0;
        wait_out("key", EST, 1'b1, 5);
        wait_out("supply", SUP, 1'b0, 5);
        @(posedge clk);
        key_on <= 1'b1;
        plc.drive(C_SEL, 1'b0);
        plc.drive(C_EST, 1'b0);
        ob("estop", EST, 1'b1);
        ob("ready", RDY, 1'b0);
    endtask : sc_stop

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        sc_regs();
        sc_access();
        sc_fire();
        sc_repeat();
        sc_energy();
        sc_temp();
        sc_stop();
        print_verdict();
    end
endmodule : ldio_ctrl_tb
